// ### logic/dac_map_pkg.sv
// Constants shared by the converter command decoder and its serial frame port
package dac_map_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int         FRAME_BITS       = 24;
  localparam logic [4:0] FRAME_COUNT_FULL = 5'd24;
  localparam logic [4:0] FRAME_MSB_INDEX  = 5'd23;
  localparam int         CMD_MSB          = 23;
  localparam int         CMD_LSB          = 16;

  // ----------------------------------------------------------------
  // Address byte codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NOP           = 8'h00;
  localparam logic [7:0] CMD_WRITE_CODE    = 8'h01;
  localparam logic [7:0] CMD_READ          = 8'h02;
  localparam logic [7:0] CMD_WRITE_CONTROL = 8'h55;
  localparam logic [7:0] CMD_WRITE_RESET   = 8'h56;
  localparam logic [7:0] CMD_WRITE_CONFIG  = 8'h57;
  localparam logic [7:0] CMD_WRITE_GAIN    = 8'h58;
  localparam logic [7:0] CMD_WRITE_OFFSET  = 8'h59;
  localparam logic [7:0] CMD_WATCHDOG      = 8'h95;

  // ----------------------------------------------------------------
  // Read addresses (six low bits of the data word; status, code and control decode only the two low bits)
  // ----------------------------------------------------------------
  localparam logic [1:0] RD_STATUS  = 2'h0;
  localparam logic [1:0] RD_CODE    = 2'h1;
  localparam logic [1:0] RD_CONTROL = 2'h2;
  localparam logic [5:0] RD_CONFIG  = 6'h0b;
  localparam logic [5:0] RD_GAIN    = 6'h13;
  localparam logic [5:0] RD_OFFSET  = 6'h17;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CLEAR_LEVEL_BIT = 15;
  localparam int OVEREXTEND_BIT  = 14;
  localparam int EXT_RES_BIT     = 13;
  localparam int OUT_EN_BIT      = 12;
  localparam int RAMP_CLK_MSB    = 11;
  localparam int RAMP_CLK_LSB    = 8;
  localparam int RAMP_STEP_MSB   = 7;
  localparam int RAMP_STEP_LSB   = 5;
  localparam int RAMP_EN_BIT     = 4;
  localparam int CHAIN_BIT       = 3;
  localparam int RANGE_MSB       = 2;
  localparam int RANGE_LSB       = 0;

  // Other fields
  localparam int DUAL_OUT_BIT    = 8;
  localparam int SOFT_RESET_BIT  = 0;
  localparam int ST_FRAME_BIT    = 4;
  localparam int ST_TIMEOUT_BIT  = 3;
  localparam int ST_LOOP_BIT     = 2;
  localparam int ST_RAMP_BIT     = 1;
  localparam int ST_TEMP_BIT     = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET  = 16'h0000;
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [15:0] TRIM_RESET    = 16'h0000;
  localparam logic [15:0] MASK_12BIT    = 16'hfff0;
  localparam logic [15:0] CODE_ZERO     = 16'h0000;
  localparam logic [15:0] CODE_MID      = 16'h8000;

  // Range codes: voltage spans below, current spans above
  localparam logic [2:0] RANGE_V_BIPOLAR_LO = 3'h2;
  localparam logic [2:0] RANGE_V_BIPOLAR_HI = 3'h3;
  localparam logic [2:0] RANGE_I_FIRST      = 3'h5;

endpackage

// ### logic/serial_frame_port.sv
// Serial frame shifter running on the serial clock
`timescale 1ns/1ps
`default_nettype none

module serial_frame_port
(
  // Link clock and reset
  input  wire logic        sclk,
  input  wire logic        rst,
  // Serial pins
  input  wire logic        latch_pin,
  input  wire logic        sdi_pin,
  output logic             serial_out_pin,
  // Register side, quasi-static around latch
  input  wire logic        chain_mode_enable,
  input  wire logic [23:0] readback_word,
  output logic [23:0]      frame_word
);

  logic [4:0] bit_count_reg;
  logic       frame_clear;

  // Latch high marks a frame boundary; the clock is idle then
  assign frame_clear = rst | latch_pin;

  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
      frame_word <= 24'h000000;
    else
      frame_word <= {frame_word[22:0], sdi_pin};
  end

  always_ff @(posedge sclk or posedge frame_clear)
  begin
    if (frame_clear)
      bit_count_reg <= 5'h00;
    else if (bit_count_reg != dac_map_pkg::FRAME_COUNT_FULL)
      bit_count_reg <= bit_count_reg + 5'h01;
  end

  // Bit 23 of the readback word is always zero, so the clear value is its MSB
  always_ff @(negedge sclk or posedge frame_clear)
  begin
    if (frame_clear)
      serial_out_pin <= 1'b0;
    else if (bit_count_reg != dac_map_pkg::FRAME_COUNT_FULL)
      serial_out_pin <= readback_word[dac_map_pkg::FRAME_MSB_INDEX - bit_count_reg];
    else if (chain_mode_enable)
      serial_out_pin <= frame_word[23];
    else
      serial_out_pin <= 1'b0;
  end

endmodule

`default_nettype wire

// ### logic/dac_command_register_map.sv
// Command decoder and register map of a single-channel current/voltage output converter
`timescale 1ns/1ps
`default_nettype none

module dac_command_register_map
#(
  parameter bit TWELVE_BIT_VARIANT = 1'b0
)
(
  // Clock, reset, enable
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Serial link
  input  wire logic         sclk,
  input  wire logic         latch_pin,
  input  wire logic         sdi_pin,
  output logic              serial_out_pin,
  // Clear and fault inputs
  input  wire logic         clear_pin,
  input  wire logic         current_loop_fault_pin,
  input  wire logic         overtemp_fault_pin,
  input  wire logic         frame_check_fault,
  input  wire logic         timeout_fault,
  // Output stage controls
  output logic              voltage_output_enable,
  output logic              current_output_enable,
  output logic [2:0]        range_select,
  output logic              range_overextend,
  output logic              external_resistor_select,
  output logic              clear_level_select,
  output logic              ramp_enable,
  output logic [3:0]        ramp_clock_select,
  output logic [2:0]        ramp_step_select,
  output logic              ramp_active,
  output logic              chain_mode_enable,
  output logic [15:0]       output_code,
  // Calibration and configuration
  output logic [15:0]       gain_trim,
  output logic signed [15:0] offset_trim,
  output logic [15:0]       output_configuration,
  output logic              watchdog_restart
);

  typedef enum logic [0:0] {RAMP_IDLE, RAMP_MOVING} ramp_state_type;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic range_is_current(input logic [2:0] range);
    return range >= dac_map_pkg::RANGE_I_FIRST;
  endfunction

  function automatic logic range_is_bipolar(input logic [2:0] range);
    return range == dac_map_pkg::RANGE_V_BIPOLAR_LO || range == dac_map_pkg::RANGE_V_BIPOLAR_HI;
  endfunction

  function automatic logic [15:0] trim_low_nibble(input logic [15:0] word);
    return TWELVE_BIT_VARIANT ? (word & dac_map_pkg::MASK_12BIT) : word;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [23:0]    frame_word;
  logic [23:0]    readback_word_reg;
  logic [15:0]    control_reg;
  logic [15:0]    config_reg;
  logic [15:0]    code_reg;
  logic [15:0]    gain_reg;
  logic [15:0]    offset_reg;
  logic [2:0]     latch_sync_reg;
  logic [1:0]     clear_sync_reg;
  logic [1:0]     loop_sync_reg;
  logic [1:0]     temp_sync_reg;
  logic           after_reset_reg;
  logic           commit;
  logic [7:0]     cmd;
  logic [15:0]    data_word;
  logic           soft_reset;
  logic [15:0]    read_value;
  logic [15:0]    status_word;
  logic [15:0]    clear_code;
  logic [15:0]    target_code;
  logic [15:0]    tick_count_reg;
  logic [15:0]    tick_period;
  logic [15:0]    step_size;
  logic [15:0]    distance;
  ramp_state_type ramp_state_reg;
  ramp_state_type ramp_state_next;
  logic [15:0]    code_next;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Frame word and readback word are held still while latch is high and
  // the serial clock is idle; the synchronised latch edge qualifies them.
  serial_frame_port frame_port
  (
    .sclk              (sclk),
    .rst               (rst),
    .latch_pin         (latch_pin),
    .sdi_pin           (sdi_pin),
    .serial_out_pin    (serial_out_pin),
    .chain_mode_enable (control_reg[dac_map_pkg::CHAIN_BIT]),
    .readback_word     (readback_word_reg),
    .frame_word        (frame_word)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      latch_sync_reg <= 3'h0;
      clear_sync_reg <= 2'h0;
      loop_sync_reg  <= 2'h0;
      temp_sync_reg  <= 2'h0;
    end
    else if (ce)
    begin
      latch_sync_reg <= {latch_sync_reg[1:0], latch_pin};
      clear_sync_reg <= {clear_sync_reg[0], clear_pin};
      loop_sync_reg  <= {loop_sync_reg[0], current_loop_fault_pin};
      temp_sync_reg  <= {temp_sync_reg[0], overtemp_fault_pin};
    end
  end

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign commit     = ce && latch_sync_reg[1] && !latch_sync_reg[2];
  assign cmd        = frame_word[dac_map_pkg::CMD_MSB:dac_map_pkg::CMD_LSB];
  assign data_word  = frame_word[15:0];
  assign soft_reset = commit && cmd == dac_map_pkg::CMD_WRITE_RESET
                      && data_word[dac_map_pkg::SOFT_RESET_BIT];

  always_comb
  begin
    status_word = 16'h0000;
    status_word[dac_map_pkg::ST_FRAME_BIT]   = frame_check_fault;
    status_word[dac_map_pkg::ST_TIMEOUT_BIT] = timeout_fault;
    status_word[dac_map_pkg::ST_LOOP_BIT]    = loop_sync_reg[1];
    status_word[dac_map_pkg::ST_RAMP_BIT]    = ramp_state_reg == RAMP_MOVING;
    status_word[dac_map_pkg::ST_TEMP_BIT]    = temp_sync_reg[1];
  end

  always_comb
  begin
    read_value = 16'h0000;
    case (data_word[5:0])
      dac_map_pkg::RD_CONFIG: read_value = config_reg;
      dac_map_pkg::RD_GAIN:   read_value = gain_reg;
      dac_map_pkg::RD_OFFSET: read_value = offset_reg;
      default:
      begin
        case (data_word[1:0])
          dac_map_pkg::RD_STATUS:  read_value = status_word;
          dac_map_pkg::RD_CODE:    read_value = code_reg;
          dac_map_pkg::RD_CONTROL: read_value = control_reg;
          default:                 read_value = 16'h0000;
        endcase
      end
    endcase
  end

  // Readback is staged for the next frame only; other commands clear it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      readback_word_reg <= 24'h000000;
    else if (commit)
    begin
      if (cmd == dac_map_pkg::CMD_READ)
        readback_word_reg <= {8'h00, read_value};
      else
        readback_word_reg <= 24'h000000;
    end
  end

  // ----------------------------------------------------------------
  // Stored registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      control_reg <= dac_map_pkg::CONTROL_RESET;
    else if (soft_reset)
      control_reg <= dac_map_pkg::CONTROL_RESET;
    else if (commit && cmd == dac_map_pkg::CMD_WRITE_CONTROL)
      control_reg <= data_word;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      config_reg <= dac_map_pkg::CONFIG_RESET;
    else if (soft_reset)
      config_reg <= dac_map_pkg::CONFIG_RESET;
    else if (commit && cmd == dac_map_pkg::CMD_WRITE_CONFIG)
      config_reg <= data_word;
  end

  // No-op, read and watchdog codes fall through with no store
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      code_reg   <= dac_map_pkg::CODE_RESET;
      gain_reg   <= dac_map_pkg::TRIM_RESET;
      offset_reg <= dac_map_pkg::TRIM_RESET;
    end
    else if (soft_reset)
    begin
      code_reg   <= dac_map_pkg::CODE_RESET;
      gain_reg   <= dac_map_pkg::TRIM_RESET;
      offset_reg <= dac_map_pkg::TRIM_RESET;
    end
    else if (commit)
    begin
      case (cmd)
        dac_map_pkg::CMD_WRITE_CODE:   code_reg   <= trim_low_nibble(data_word);
        dac_map_pkg::CMD_WRITE_GAIN:   gain_reg   <= trim_low_nibble(data_word);
        dac_map_pkg::CMD_WRITE_OFFSET: offset_reg <= trim_low_nibble(data_word);
        default:                       code_reg   <= code_reg;
      endcase
    end
  end

  // Clear level holds until the first code write after any reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      after_reset_reg <= 1'b1;
    else if (soft_reset)
      after_reset_reg <= 1'b1;
    else if (commit && cmd == dac_map_pkg::CMD_WRITE_CODE)
      after_reset_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      watchdog_restart <= 1'b0;
    else if (ce)
      watchdog_restart <= commit && cmd == dac_map_pkg::CMD_WATCHDOG;
  end

  // ----------------------------------------------------------------
  // Output stage controls
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      voltage_output_enable    <= 1'b0;
      current_output_enable    <= 1'b0;
      range_select             <= 3'h0;
      range_overextend         <= 1'b0;
      external_resistor_select <= 1'b0;
      clear_level_select       <= 1'b0;
      ramp_enable              <= 1'b0;
      ramp_clock_select        <= 4'h0;
      ramp_step_select         <= 3'h0;
      chain_mode_enable        <= 1'b0;
      gain_trim                <= dac_map_pkg::TRIM_RESET;
      offset_trim              <= dac_map_pkg::TRIM_RESET;
      output_configuration     <= dac_map_pkg::CONFIG_RESET;
    end
    else if (ce)
    begin
      voltage_output_enable    <= control_reg[dac_map_pkg::OUT_EN_BIT]
                                  && (!range_is_current(control_reg[2:0])
                                      || config_reg[dac_map_pkg::DUAL_OUT_BIT]);
      current_output_enable    <= control_reg[dac_map_pkg::OUT_EN_BIT]
                                  && (range_is_current(control_reg[2:0])
                                      || config_reg[dac_map_pkg::DUAL_OUT_BIT]);
      range_select             <= control_reg[dac_map_pkg::RANGE_MSB:dac_map_pkg::RANGE_LSB];
      range_overextend         <= control_reg[dac_map_pkg::OVEREXTEND_BIT];
      external_resistor_select <= control_reg[dac_map_pkg::EXT_RES_BIT];
      clear_level_select       <= control_reg[dac_map_pkg::CLEAR_LEVEL_BIT];
      ramp_enable              <= control_reg[dac_map_pkg::RAMP_EN_BIT];
      ramp_clock_select        <= control_reg[dac_map_pkg::RAMP_EN_BIT]
                                  ? control_reg[dac_map_pkg::RAMP_CLK_MSB:dac_map_pkg::RAMP_CLK_LSB]
                                  : 4'h0;
      ramp_step_select         <= control_reg[dac_map_pkg::RAMP_EN_BIT]
                                  ? control_reg[dac_map_pkg::RAMP_STEP_MSB:dac_map_pkg::RAMP_STEP_LSB]
                                  : 3'h0;
      chain_mode_enable        <= control_reg[dac_map_pkg::CHAIN_BIT];
      gain_trim                <= gain_reg;
      offset_trim              <= signed'(offset_reg);
      output_configuration     <= config_reg;
    end
  end

  // ----------------------------------------------------------------
  // Clear level and ramp
  // ----------------------------------------------------------------
  always_comb
  begin
    if (range_is_bipolar(control_reg[2:0]))
      clear_code = control_reg[dac_map_pkg::CLEAR_LEVEL_BIT]
                   ? dac_map_pkg::CODE_ZERO : dac_map_pkg::CODE_MID;
    else
      clear_code = control_reg[dac_map_pkg::CLEAR_LEVEL_BIT]
                   ? dac_map_pkg::CODE_MID : dac_map_pkg::CODE_ZERO;
    target_code = (clear_sync_reg[1] || after_reset_reg) ? clear_code : code_reg;
  end

  // Rate is a power-of-two divider; exact slew tables belong to the analog side
  assign tick_period = 16'h0001 << control_reg[dac_map_pkg::RAMP_CLK_MSB:dac_map_pkg::RAMP_CLK_LSB];
  assign step_size   = 16'h0001 << control_reg[dac_map_pkg::RAMP_STEP_MSB:dac_map_pkg::RAMP_STEP_LSB];
  assign distance    = (output_code > target_code) ? output_code - target_code
                                                   : target_code - output_code;

  always_comb
  begin
    ramp_state_next = ramp_state_reg;
    code_next       = output_code;
    case (ramp_state_reg)
      RAMP_IDLE:
      begin
        if (!control_reg[dac_map_pkg::RAMP_EN_BIT])
          code_next = target_code;
        else if (output_code != target_code)
          ramp_state_next = RAMP_MOVING;
      end
      RAMP_MOVING:
      begin
        if (!control_reg[dac_map_pkg::RAMP_EN_BIT] || output_code == target_code)
        begin
          code_next       = target_code;
          ramp_state_next = RAMP_IDLE;
        end
        else if (tick_count_reg + 16'h0001 >= tick_period)
        begin
          if (distance <= step_size)
            code_next = target_code;
          else if (output_code > target_code)
            code_next = output_code - step_size;
          else
            code_next = output_code + step_size;
        end
      end
      default:
      begin
        ramp_state_next = RAMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      tick_count_reg <= 16'h0000;
    else if (ce)
    begin
      if (ramp_state_reg != RAMP_MOVING || tick_count_reg + 16'h0001 >= tick_period)
        tick_count_reg <= 16'h0000;
      else
        tick_count_reg <= tick_count_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ramp_state_reg <= RAMP_IDLE;
      output_code    <= dac_map_pkg::CODE_ZERO;
      ramp_active    <= 1'b0;
    end
    else if (ce)
    begin
      ramp_state_reg <= ramp_state_next;
      output_code    <= code_next;
      ramp_active    <= ramp_state_next == RAMP_MOVING;
    end
  end

endmodule

`default_nettype wire

// ### tb/host_serial_model.sv
// Host controller model: serial bursts of 24 clocks per device, latch pulse, readback capture
`timescale 1ns/1ps
`default_nettype none

module host_serial_model
(
  // Serial pins
  output logic      sclk,
  output logic      latch_pin,
  output logic      sdi_pin,
  input  wire logic serial_out_pin
);
  initial
  begin
    sclk      = 1'b0;
    latch_pin = 1'b0;
    sdi_pin   = 1'b0;
  end

  // Clock runs only inside a frame; 24 rising edges per chained device before latch
  task automatic xfer(input logic [47:0] tx, input int nbits, output logic [47:0] rx);
    rx = 48'h000000000000;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sdi_pin = tx[i];
      #6 sclk = 1'b1;
      rx = {rx[46:0], serial_out_pin};
      #6 sclk = 1'b0;
    end
    // Released data line must not keep looking valid
    sdi_pin = ~sdi_pin;
    #2 latch_pin = 1'b1;
    #40 latch_pin = 1'b0;
    #4;
  endtask
endmodule

`default_nettype wire

// ### tb/dac_map_monitor.sv
// Port-level assertions for the converter register map
`timescale 1ns/1ps
`default_nettype none

module dac_map_monitor
#(
  parameter bit TWELVE_BIT_VARIANT = 1'b0
)
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Watched ports
  input wire logic        latch_pin,
  input wire logic        clear_pin,
  input wire logic        voltage_output_enable,
  input wire logic        current_output_enable,
  input wire logic [2:0]  range_select,
  input wire logic        clear_level_select,
  input wire logic        ramp_enable,
  input wire logic [3:0]  ramp_clock_select,
  input wire logic [2:0]  ramp_step_select,
  input wire logic [15:0] output_code,
  input wire logic [15:0] gain_trim,
  input wire logic [15:0] output_configuration,
  input wire logic        watchdog_restart
);
  // Cycles since latch dropped; stored state may only move near a commit
  logic [3:0] since_latch;
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      since_latch <= 4'h0;
    else if (latch_pin)
      since_latch <= 4'h0;
    else if (since_latch != 4'hf)
      since_latch <= since_latch + 4'h1;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_commit_only;
    $changed(range_select) || $changed(gain_trim) |-> since_latch < 4'h2;
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("state moved with no frame");
  property p_wd_pulse;
    watchdog_restart |-> since_latch < 4'h2 ##1 !watchdog_restart;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) else $error("restart pulse wrong");
  property p_reset_zero;
    $fell(rst) |-> {voltage_output_enable, current_output_enable, range_select} == 5'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero at reset");
  property p_ramp_gate;
    !ramp_enable |-> ramp_clock_select == 4'h0 && ramp_step_select == 3'h0;
  endproperty
  a_ramp_gate: assert property (p_ramp_gate) else $error("ramp fields not gated");
  property p_one_output;
    voltage_output_enable && current_output_enable |-> output_configuration[8];
  endproperty
  a_one_output: assert property (p_one_output) else $error("both outputs on");
  property p_range_type;
    !output_configuration[8] |->
      !(range_select < 3'h5 ? current_output_enable : voltage_output_enable);
  endproperty
  a_range_type: assert property (p_range_type) else $error("wrong output type");
  property p_trim_nibble;
    TWELVE_BIT_VARIANT |-> gain_trim[3:0] == 4'h0;
  endproperty
  a_trim_nibble: assert property (p_trim_nibble) else $error("low nibble stored");
  property p_clear_code;
    clear_pin [*6] ##0 (!ramp_enable && since_latch > 4'h8) |-> output_code ==
      (((range_select == 3'h2 || range_select == 3'h3) != clear_level_select) ? 16'h8000 : 16'h0000);
  endproperty
  a_clear_code: assert property (p_clear_code) else $error("clear code wrong");
endmodule

bind dac_command_register_map dac_map_monitor #(.TWELVE_BIT_VARIANT(TWELVE_BIT_VARIANT)) mon
(
  .ref_clk(ref_clk), .rst(rst), .latch_pin(latch_pin), .clear_pin(clear_pin),
  .voltage_output_enable(voltage_output_enable), .current_output_enable(current_output_enable),
  .range_select(range_select), .clear_level_select(clear_level_select),
  .ramp_enable(ramp_enable), .ramp_clock_select(ramp_clock_select),
  .ramp_step_select(ramp_step_select), .output_code(output_code), .gain_trim(gain_trim),
  .output_configuration(output_configuration), .watchdog_restart(watchdog_restart)
);

`default_nettype wire

// ### tb/dac_command_register_map_tb_top.sv
// Testbench for the converter command decoder and register map
`timescale 1ns/1ps
`default_nettype none

module dac_command_register_map_tb_top;
  logic        ref_clk, rst, ce, clear_pin, temp_flt, frm_flt, loop_flt, tmo_flt;
  logic        sclk, latch_pin, sdi_pin, serial_out_pin;
  logic        voe, coe, clr_sel, ramp_act, wdr, over_ext, ext_res, ramp_on, chain_on;
  logic [2:0]  rng, rstep;
  logic [3:0]  rclk;
  logic [15:0] code, offs, gain, cfg;
  logic [47:0] rx48;
  logic [23:0] wd_cnt = 24'h0;
  int          n_fail = 0;
  int          samples_checked = 0;

  host_serial_model host (.sclk(sclk), .latch_pin(latch_pin), .sdi_pin(sdi_pin),
    .serial_out_pin(serial_out_pin));
  dac_command_register_map #(.TWELVE_BIT_VARIANT(1'b1)) uut (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .sclk(sclk), .latch_pin(latch_pin),
    .sdi_pin(sdi_pin), .serial_out_pin(serial_out_pin), .clear_pin(clear_pin),
    .current_loop_fault_pin(loop_flt), .overtemp_fault_pin(temp_flt),
    .frame_check_fault(frm_flt), .timeout_fault(tmo_flt), .voltage_output_enable(voe),
    .current_output_enable(coe), .range_select(rng), .range_overextend(over_ext),
    .external_resistor_select(ext_res), .clear_level_select(clr_sel), .ramp_enable(ramp_on),
    .ramp_clock_select(rclk), .ramp_step_select(rstep), .ramp_active(ramp_act),
    .chain_mode_enable(chain_on), .output_code(code), .gain_trim(gain), .offset_trim(offs),
    .output_configuration(cfg), .watchdog_restart(wdr));

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (wdr === 1'b1)
      wd_cnt <= wd_cnt + 24'h1;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [47:0] r;
    host.xfer({24'h000000, a, d}, 24, r);
    repeat (6) @(negedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    logic [47:0] r;
    wr(dac_map_pkg::CMD_READ, {10'h000, a});
    host.xfer({24'h000000, dac_map_pkg::CMD_NOP, 16'h0000}, 24, r);
    chk(r[23:0], {8'h00, exp});
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_fail++;
    conclude();
  end

  initial
  begin
    rst       = 1'b1;
    ce        = 1'b1;
    clear_pin = 1'b0;
    temp_flt  = 1'b1;
    frm_flt   = 1'b1;
    loop_flt  = 1'b1;
    tmo_flt   = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    rd(6'(dac_map_pkg::RD_CONTROL), 16'h0000);
    rd(6'h00, 16'h001d);
    $display("test reset_status done");
    wr(dac_map_pkg::CMD_WRITE_CONTROL, 16'h9fe2);
    chk({11'h000, voe, coe, rng, clr_sel, rclk, rstep}, 24'h001280);
    rd(6'(dac_map_pkg::RD_CONTROL), 16'h9fe2);
    wr(dac_map_pkg::CMD_NOP, 16'hffff);
    wr(dac_map_pkg::CMD_WATCHDOG, 16'hffff);
    wr(dac_map_pkg::CMD_READ, 16'h0017);
    rd(6'(dac_map_pkg::RD_CONTROL), 16'h9fe2);
    chk(wd_cnt, 24'h000001);
    // Code written first, so the clear pin alone must pull the output away
    wr(dac_map_pkg::CMD_WRITE_CODE, 16'h1230);
    // Bipolar range: clear level low gives midscale code, high gives zero code
    for (int i = 0; i < 2; i++)
    begin
      wr(dac_map_pkg::CMD_WRITE_CONTROL, {i[0], 15'h1002});
      clear_pin = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk({8'h00, code}, {8'h00, ~i[0], 15'h0000});
      clear_pin = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({8'h00, code}, 24'h001230);
    end
    wr(dac_map_pkg::CMD_WRITE_CONTROL, 16'h6008);
    chk({20'h00000, over_ext, ext_res, chain_on, ramp_on}, 24'h00000e);
    // Two-device frame: the first 24 bits must come back out behind the readback
    host.xfer({24'ha5c3e1, dac_map_pkg::CMD_WRITE_CONTROL, 16'h6008}, 48, rx48);
    chk(rx48[23:0], 24'ha5c3e1);
    chk(rx48[47:24], 24'h000000);
    $display("test control done");
    wr(dac_map_pkg::CMD_WRITE_CODE, 16'habcd);
    chk({8'h00, code}, 24'h00abc0);
    rd(6'(dac_map_pkg::RD_CODE), 16'habc0);
    wr(dac_map_pkg::CMD_WRITE_GAIN, 16'h123f);
    wr(dac_map_pkg::CMD_WRITE_OFFSET, 16'hfedc);
    rd(dac_map_pkg::RD_GAIN, 16'h1230);
    rd(dac_map_pkg::RD_OFFSET, 16'hfed0);
    chk({8'h00, offs}, 24'h00fed0);
    chk({8'h00, gain}, 24'h001230);
    wr(dac_map_pkg::CMD_WRITE_CONFIG, 16'h0100);
    rd(dac_map_pkg::RD_CONFIG, 16'h0100);
    chk({8'h00, cfg}, 24'h000100);
    wr(dac_map_pkg::CMD_WRITE_CONTROL, 16'h10f2);
    wr(dac_map_pkg::CMD_WRITE_CODE, 16'h0000);
    chk({18'h00000, voe, coe, ramp_act, rstep}, 24'h00003f);
    repeat (600) @(negedge ref_clk);
    chk({7'h00, ramp_act, code}, 24'h000000);
    wr(dac_map_pkg::CMD_WRITE_RESET, 16'h0001);
    rd(6'(dac_map_pkg::RD_CONTROL), 16'h0000);
    chk({8'h00, cfg}, 24'h000000);
    $display("test data_ramp done");
    conclude();
  end
endmodule

`default_nettype wire
